//--- src/fts_flash_timing.sv
// Flash program and erase timing registers, sequencer and auto-read copies.
// Assumes a CPU register port on the system clock and a flash array that
// reports its own activity level asynchronously.
// Function
// - Start delay lasts field plus one ticks
// - Transitions last field plus one ticks
// - Program pulse is eight times field plus one
// - Page erase is 4096 times field plus one
// - Module erase is 4096 times field plus one
// - End delay lasts field plus one ticks
// - Module erase end is eight times field plus one
// - Recovery lasts field plus one ticks
// - Defaults load at reset only if idle
// - Function word copy sampled at reset, read-only
// - USB enable zero forces transceiver low power
// - Protection word copy sampled at reset, read-only
// - Code start word loaded at reset, read-only
// - Code start bits 8:0, 15:13 read zero
// - Code start bits 12:9 invert boot field
// - Data-side aliases return the same values
// - Prescaler divides clock by divider plus one
// - Busy flag while operating; requests stall
`timescale 1ns/10ps
`default_nettype none
module fts_flash_timing
  import fts_pkg::*;
#(
  parameter int ERASE_SHIFT = ERASE_SHIFT_DEF
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // CPU register port.
  input  wire logic [3:0]  reg_idx_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  // Operation requests from the CPU side.
  input  wire logic        op_req_i,
  input  wire logic [1:0]  op_kind_i,
  output logic             cpu_stall_o,
  output logic             flash_busy_flag_o,
  output logic             op_done_o,
  // Flash array side.
  input  wire logic        array_active_i,
  input  wire logic [15:0] info0_word_i,
  input  wire logic [15:0] info1_word_i,
  output logic [2:0]       seq_phase_o,
  output logic             program_pulse_o,
  output logic             erase_pulse_o,
  output logic             module_erase_o,
  // USB transceiver power control.
  input  wire logic        usb_ctrl_lowpower_i,
  output logic             usb_xcvr_lowpower_o
);

  localparam int CNT_W = 9 + ERASE_SHIFT;

  // Timing reload registers.
  logic [7:0]  start_delay_reload_reg;
  logic [7:0]  transition_time_reload_reg;
  logic [7:0]  program_pulse_reload_reg;
  logic [7:0]  page_erase_pulse_reload_reg;
  logic [7:0]  module_erase_pulse_reload_reg;
  logic [7:0]  end_delay_reload_reg;
  logic [7:0]  module_erase_end_reload_reg;
  logic [7:0]  recovery_delay_reload_reg;
  logic [4:0]  prescaler_divider_reg;
  logic [7:0]  start_delay_reload_next;
  logic [7:0]  transition_time_reload_next;
  logic [7:0]  program_pulse_reload_next;
  logic [7:0]  page_erase_pulse_reload_next;
  logic [7:0]  module_erase_pulse_reload_next;
  logic [7:0]  end_delay_reload_next;
  logic [7:0]  module_erase_end_reload_next;
  logic [7:0]  recovery_delay_reload_next;
  logic [4:0]  prescaler_divider_next;

  // Auto-read copies and the read data register.
  logic [15:0] function_word_copy_reg;
  logic [15:0] protection_word_copy_reg;
  logic [15:0] code_area_start_copy_reg;
  logic [15:0] function_word_copy_next;
  logic [15:0] protection_word_copy_next;
  logic [15:0] code_area_start_copy_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        usb_lowpower_reg;
  logic        usb_lowpower_next;

  // Sequencer state.
  fts_state_t  state_reg;
  fts_state_t  state_next;
  logic [1:0]  op_kind_reg;
  logic [1:0]  op_kind_next;
  logic [4:0]  psc_cnt_reg;
  logic [4:0]  psc_cnt_next;
  logic        done_reg;
  logic        done_next;

  // Glue.
  logic              array_active;
  logic              busy;
  logic              tick;
  logic              phase_done;
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_val;
  logic              take_req;

  // Flash array activity from its own domain.
  fts_sync3 u_active_sync (
    .clk_i   (clk_i),
    .async_i (array_active_i),
    .level_o (array_active)
  );

  // Phase length counter.
  fts_delay_cnt #(
    .W (CNT_W)
  ) u_phase_cnt (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (cnt_load),
    .load_val_i (cnt_val),
    .tick_i     (tick),
    .done_o     (phase_done)
  );

  // Field plus one, scaled by a power of two, as a tick count.
  function automatic logic [CNT_W-1:0] scaled(input logic [7:0] field, input int shift);
    logic [CNT_W-1:0] ext;
    ext    = CNT_W'({1'b0, field} + 9'h001);
    scaled = ext << shift;
  endfunction

  // Busy covers the whole sequence and any operation the array still runs.
  assign busy     = (state_reg != SEQ_IDLE) || array_active;
  assign take_req = op_req_i && !busy && (op_kind_i != 2'h0);

  // Timing registers: defaults only when the flash is idle at reset.
  always_comb begin
    start_delay_reload_next        = start_delay_reload_reg;
    transition_time_reload_next    = transition_time_reload_reg;
    program_pulse_reload_next      = program_pulse_reload_reg;
    page_erase_pulse_reload_next   = page_erase_pulse_reload_reg;
    module_erase_pulse_reload_next = module_erase_pulse_reload_reg;
    end_delay_reload_next          = end_delay_reload_reg;
    module_erase_end_reload_next   = module_erase_end_reload_reg;
    recovery_delay_reload_next     = recovery_delay_reload_reg;
    prescaler_divider_next         = prescaler_divider_reg;
    if (rst_i) begin
      if (!array_active) begin
        start_delay_reload_next        = RST_START_DELAY;
        transition_time_reload_next    = RST_TRANSITION;
        program_pulse_reload_next      = RST_PROGRAM_PULSE;
        page_erase_pulse_reload_next   = RST_PAGE_ERASE;
        module_erase_pulse_reload_next = RST_MODULE_ERASE;
        end_delay_reload_next          = RST_END_DELAY;
        module_erase_end_reload_next   = RST_MODULE_END;
        recovery_delay_reload_next     = RST_RECOVERY;
        prescaler_divider_next         = RST_PRESCALER;
      end
    end else if (reg_wr_i) begin
      // Writes during an operation are software's fault and are not blocked.
      case (reg_idx_i)
        IDX_START_DELAY:   start_delay_reload_next        = reg_wdata_i[7:0];
        IDX_TRANSITION:    transition_time_reload_next    = reg_wdata_i[7:0];
        IDX_PROGRAM_PULSE: program_pulse_reload_next      = reg_wdata_i[7:0];
        IDX_PAGE_ERASE:    page_erase_pulse_reload_next   = reg_wdata_i[7:0];
        IDX_MODULE_ERASE:  module_erase_pulse_reload_next = reg_wdata_i[7:0];
        IDX_END_DELAY:     end_delay_reload_next          = reg_wdata_i[7:0];
        IDX_MODULE_END:    module_erase_end_reload_next   = reg_wdata_i[7:0];
        IDX_RECOVERY:      recovery_delay_reload_next     = reg_wdata_i[7:0];
        IDX_PRESCALER:     prescaler_divider_next         = reg_wdata_i[4:0];
        default: begin
        end
      endcase
    end
  end

  // Timing register storage.
  always_ff @(posedge clk_i) begin
    start_delay_reload_reg        <= start_delay_reload_next;
    transition_time_reload_reg    <= transition_time_reload_next;
    program_pulse_reload_reg      <= program_pulse_reload_next;
    page_erase_pulse_reload_reg   <= page_erase_pulse_reload_next;
    module_erase_pulse_reload_reg <= module_erase_pulse_reload_next;
    end_delay_reload_reg          <= end_delay_reload_next;
    module_erase_end_reload_reg   <= module_erase_end_reload_next;
    recovery_delay_reload_reg     <= recovery_delay_reload_next;
    prescaler_divider_reg         <= prescaler_divider_next;
  end

  // Auto-read copies are sampled while reset is held and never written by the CPU.
  always_comb begin
    function_word_copy_next   = function_word_copy_reg;
    protection_word_copy_next = protection_word_copy_reg;
    code_area_start_copy_next = code_area_start_copy_reg;
    if (rst_i) begin
      function_word_copy_next   = info0_word_i;
      protection_word_copy_next = info1_word_i;
      code_area_start_copy_next = 16'h0000;
      code_area_start_copy_next[CODE_AREA_LSB +: 4] =
        ~info1_word_i[BOOT_AREA_LSB +: 4];
    end
  end

  // Transceiver forced to low power unless the function word enables it.
  always_comb begin
    usb_lowpower_next = !function_word_copy_reg[USB_ENABLE_BIT] || usb_ctrl_lowpower_i;
  end

  // Registered read data; aliases decode to the same copies.
  always_comb begin
    rdata_next = rdata_reg;
    if (rst_i) begin
      rdata_next = 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_idx_i)
        IDX_START_DELAY:   rdata_next = {8'h00, start_delay_reload_reg};
        IDX_TRANSITION:    rdata_next = {8'h00, transition_time_reload_reg};
        IDX_PROGRAM_PULSE: rdata_next = {8'h00, program_pulse_reload_reg};
        IDX_PAGE_ERASE:    rdata_next = {8'h00, page_erase_pulse_reload_reg};
        IDX_MODULE_ERASE:  rdata_next = {8'h00, module_erase_pulse_reload_reg};
        IDX_END_DELAY:     rdata_next = {8'h00, end_delay_reload_reg};
        IDX_MODULE_END:    rdata_next = {8'h00, module_erase_end_reload_reg};
        IDX_RECOVERY:      rdata_next = {8'h00, recovery_delay_reload_reg};
        IDX_PRESCALER:     rdata_next = {11'h000, prescaler_divider_reg};
        IDX_FUNC_WORD,
        IDX_FUNC_WORD_DM:  rdata_next = function_word_copy_reg;
        IDX_PROT_WORD,
        IDX_PROT_WORD_DM:  rdata_next = protection_word_copy_reg;
        IDX_CODE_START,
        IDX_CODE_START_DM: rdata_next = code_area_start_copy_reg;
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  // Copy, read data and transceiver control storage.
  always_ff @(posedge clk_i) begin
    function_word_copy_reg   <= function_word_copy_next;
    protection_word_copy_reg <= protection_word_copy_next;
    code_area_start_copy_reg <= code_area_start_copy_next;
    rdata_reg                <= rdata_next;
    usb_lowpower_reg         <= usb_lowpower_next;
  end

  // Prescaler: one tick every divider plus one system clocks, restarted per operation.
  always_comb begin
    psc_cnt_next = psc_cnt_reg + 5'h01;
    if (rst_i || take_req || (psc_cnt_reg == prescaler_divider_reg)) begin
      psc_cnt_next = 5'h00;
    end
  end
  assign tick = (state_reg != SEQ_IDLE) && (psc_cnt_reg == prescaler_divider_reg);

  // Sequencer walks the phases and loads each phase length on entry.
  always_comb begin
    state_next   = state_reg;
    op_kind_next = op_kind_reg;
    done_next    = 1'b0;
    cnt_load     = 1'b0;
    cnt_val      = '0;
    case (state_reg)
      SEQ_IDLE: begin
        if (take_req) begin
          state_next   = SEQ_START;
          op_kind_next = op_kind_i;
          cnt_load     = 1'b1;
          cnt_val      = scaled(start_delay_reload_reg, 0);
        end
      end
      SEQ_START: begin
        if (phase_done) begin
          state_next = SEQ_TRAN_A;
          cnt_load   = 1'b1;
          cnt_val    = scaled(transition_time_reload_reg, 0);
        end
      end
      SEQ_TRAN_A: begin
        if (phase_done) begin
          state_next = SEQ_PULSE;
          cnt_load   = 1'b1;
          case (op_kind_reg)
            OP_PAGE_ERASE:   cnt_val = scaled(page_erase_pulse_reload_reg, ERASE_SHIFT);
            OP_MODULE_ERASE: cnt_val = scaled(module_erase_pulse_reload_reg, ERASE_SHIFT);
            default:         cnt_val = scaled(program_pulse_reload_reg, PROG_SHIFT);
          endcase
        end
      end
      SEQ_PULSE: begin
        if (phase_done) begin
          state_next = SEQ_TRAN_B;
          cnt_load   = 1'b1;
          cnt_val    = scaled(transition_time_reload_reg, 0);
        end
      end
      SEQ_TRAN_B: begin
        if (phase_done) begin
          state_next = SEQ_END;
          cnt_load   = 1'b1;
          if (op_kind_reg == OP_MODULE_ERASE) begin
            cnt_val = scaled(module_erase_end_reload_reg, MODULE_END_SHIFT);
          end else begin
            cnt_val = scaled(end_delay_reload_reg, 0);
          end
        end
      end
      SEQ_END: begin
        if (phase_done) begin
          state_next = SEQ_RECOVER;
          cnt_load   = 1'b1;
          cnt_val    = scaled(recovery_delay_reload_reg, 0);
        end
      end
      SEQ_RECOVER: begin
        if (phase_done) begin
          state_next = SEQ_IDLE;
          done_next  = 1'b1;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
    if (rst_i) begin
      state_next   = SEQ_IDLE;
      op_kind_next = 2'h0;
      done_next    = 1'b0;
    end
  end

  // Sequencer storage.
  always_ff @(posedge clk_i) begin
    state_reg   <= state_next;
    op_kind_reg <= op_kind_next;
    psc_cnt_reg <= psc_cnt_next;
    done_reg    <= done_next;
  end

  // Outputs toward the CPU and the array.
  assign reg_rdata_o         = rdata_reg;
  assign flash_busy_flag_o   = busy;
  assign cpu_stall_o         = op_req_i && busy;
  assign op_done_o           = done_reg;
  assign seq_phase_o         = state_reg;
  assign program_pulse_o     = (state_reg == SEQ_PULSE) && (op_kind_reg == OP_PROGRAM);
  assign erase_pulse_o       = (state_reg == SEQ_PULSE) && (op_kind_reg != OP_PROGRAM);
  assign module_erase_o      = (op_kind_reg == OP_MODULE_ERASE) && (state_reg != SEQ_IDLE);
  assign usb_xcvr_lowpower_o = usb_lowpower_reg;

endmodule
`default_nettype wire

//--- inc/fts_pkg.sv
// Shared constants for the flash timing reload and auto-read register block.
// Assumes a single 10 MHz system clock and a CPU register port with word indices.
package fts_pkg;

  // Register indices on the CPU register port.
  localparam logic [3:0] IDX_START_DELAY   = 4'h0;
  localparam logic [3:0] IDX_TRANSITION    = 4'h1;
  localparam logic [3:0] IDX_PROGRAM_PULSE = 4'h2;
  localparam logic [3:0] IDX_PAGE_ERASE    = 4'h3;
  localparam logic [3:0] IDX_MODULE_ERASE  = 4'h4;
  localparam logic [3:0] IDX_END_DELAY     = 4'h5;
  localparam logic [3:0] IDX_MODULE_END    = 4'h6;
  localparam logic [3:0] IDX_RECOVERY      = 4'h7;
  localparam logic [3:0] IDX_PRESCALER     = 4'h8;
  localparam logic [3:0] IDX_FUNC_WORD     = 4'h9;
  localparam logic [3:0] IDX_PROT_WORD     = 4'hA;
  localparam logic [3:0] IDX_CODE_START    = 4'hB;
  localparam logic [3:0] IDX_FUNC_WORD_DM  = 4'hC;
  localparam logic [3:0] IDX_PROT_WORD_DM  = 4'hD;
  localparam logic [3:0] IDX_CODE_START_DM = 4'hE;

  // Reset values of the timing reload registers and the prescaler divider.
  localparam logic [7:0] RST_START_DELAY   = 8'h18;
  localparam logic [7:0] RST_TRANSITION    = 8'h30;
  localparam logic [7:0] RST_PROGRAM_PULSE = 8'h16;
  localparam logic [7:0] RST_PAGE_ERASE    = 8'h04;
  localparam logic [7:0] RST_MODULE_ERASE  = 8'hEA;
  localparam logic [7:0] RST_END_DELAY     = 8'h18;
  localparam logic [7:0] RST_MODULE_END    = 8'h3C;
  localparam logic [7:0] RST_RECOVERY      = 8'h04;
  localparam logic [4:0] RST_PRESCALER     = 5'h04;

  // Multipliers of the reload fields, as left shifts (8 = 2**3, 4096 = 2**12).
  localparam int PROG_SHIFT        = 3;
  localparam int MODULE_END_SHIFT  = 3;
  localparam int ERASE_SHIFT_DEF   = 12;

  // Field positions inside the auto-read words.
  localparam int USB_ENABLE_BIT    = 0;
  localparam int BOOT_AREA_LSB     = 0;
  localparam int CODE_AREA_LSB     = 9;

  // Operation kinds requested of the sequencer.
  localparam logic [1:0] OP_PROGRAM      = 2'h1;
  localparam logic [1:0] OP_PAGE_ERASE   = 2'h2;
  localparam logic [1:0] OP_MODULE_ERASE = 2'h3;

  // Sequencer phases, Gray coded on each step from idle through recovery.
  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'h0,
    SEQ_START   = 3'h1,
    SEQ_TRAN_A  = 3'h3,
    SEQ_PULSE   = 3'h2,
    SEQ_TRAN_B  = 3'h6,
    SEQ_END     = 3'h7,
    SEQ_RECOVER = 3'h5
  } fts_state_t;

endpackage

//--- src/fts_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is a level from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module fts_sync3 (
  // Clock.
  input  wire logic clk_i,
  // Asynchronous level in, filtered level out.
  input  wire logic async_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;

  // A change is accepted once the second and third stages agree.
  always_comb begin
    level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  end

  // No reset here so the level is already valid while the block is held in reset.
  always_ff @(posedge clk_i) begin
    s1_reg    <= async_i;
    s2_reg    <= s1_reg;
    s3_reg    <= s2_reg;
    level_reg <= level_next;
  end

  assign level_o = level_reg;

endmodule
`default_nettype wire

//--- src/fts_delay_cnt.sv
// Down counter that measures a phase in prescaler ticks.
// Assumes load and tick come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module fts_delay_cnt #(
  parameter int W = 21
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Load and count control.
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         tick_i,
  // Phase end, one cycle on the last tick.
  output logic              done_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Load wins; otherwise each tick removes one from a nonzero count.
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = load_val_i;
    end else if (tick_i && (cnt_reg != '0)) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  // Count register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Load is left out here: the sequencer loads on this very signal, so gating it would loop.
  assign done_o = tick_i && (cnt_reg == W'(1));

endmodule
`default_nettype wire

//--- verif/fts_flash_timing_chk.sv
// Port checker for the flash timing reload and auto-read register block.
// Assumes it is bound to fts_flash_timing and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module fts_flash_timing_chk
  import fts_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_idx_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        op_req_i,
  input wire logic [1:0]  op_kind_i,
  input wire logic        cpu_stall_o,
  input wire logic        flash_busy_flag_o,
  input wire logic        op_done_o,
  input wire logic [2:0]  seq_phase_o,
  input wire logic        program_pulse_o,
  input wire logic        erase_pulse_o,
  input wire logic        usb_ctrl_lowpower_i,
  input wire logic        usb_xcvr_lowpower_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Gives the only phase that may follow each phase.
  function automatic logic [2:0] succ(input logic [2:0] p);
    case (p)
      SEQ_IDLE:   succ = SEQ_START;
      SEQ_START:  succ = SEQ_TRAN_A;
      SEQ_TRAN_A: succ = SEQ_PULSE;
      SEQ_PULSE:  succ = SEQ_TRAN_B;
      SEQ_TRAN_B: succ = SEQ_END;
      SEQ_END:    succ = SEQ_RECOVER;
      default:    succ = SEQ_IDLE;
    endcase
  endfunction

  // A request is accepted, then the sequencer opens with the start delay.
  sequence s_take;
    op_req_i && (op_kind_i != 2'h0) && !flash_busy_flag_o;
  endsequence
  sequence s_started;
    (seq_phase_o == SEQ_START) && flash_busy_flag_o;
  endsequence

  a_take_starts: assert property (s_take |=> s_started)
    else $error("accepted request did not open the start phase");
  a_phase_order: assert property (!$stable(seq_phase_o) && !$past(rst_i) |->
    seq_phase_o == succ($past(seq_phase_o))) else $error("illegal phase step");
  a_stall_busy: assert property (cpu_stall_o == (op_req_i && flash_busy_flag_o))
    else $error("stall does not match request and busy");
  a_busy_active: assert property (seq_phase_o != SEQ_IDLE |-> flash_busy_flag_o)
    else $error("busy low while sequencer runs");
  a_done_pulse: assert property (op_done_o |-> seq_phase_o == SEQ_IDLE ##1 !op_done_o)
    else $error("done pulse not single or not idle");
  a_pulse_phase: assert property ((program_pulse_o || erase_pulse_o) |->
    seq_phase_o == SEQ_PULSE && !(program_pulse_o && erase_pulse_o))
    else $error("pulse output outside pulse phase");
  a_byte_upper: assert property (reg_rd_i && reg_idx_i <= IDX_PRESCALER |=>
    reg_rdata_o[15:8] == 8'h00) else $error("byte register upper bits not zero");
  a_code_zero: assert property (reg_rd_i && (reg_idx_i == IDX_CODE_START ||
    reg_idx_i == IDX_CODE_START_DM) |=> reg_rdata_o[8:0] == 9'h000 &&
    reg_rdata_o[15:13] == 3'h0) else $error("code start fixed bits not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_usb_follow: assert property (usb_ctrl_lowpower_i |=> usb_xcvr_lowpower_o)
    else $error("transceiver not low power on controller request");

  // Main scenario reached.
  c_take: cover property (s_take ##1 s_started);
endmodule

bind fts_flash_timing fts_flash_timing_chk u_chk (.clk_i, .rst_i, .reg_idx_i, .reg_rd_i,
  .reg_rdata_o, .op_req_i, .op_kind_i, .cpu_stall_o, .flash_busy_flag_o, .op_done_o,
  .seq_phase_o, .program_pulse_o, .erase_pulse_o, .usb_ctrl_lowpower_i, .usb_xcvr_lowpower_o);
`default_nettype wire

//--- verif/fts_array_model.sv
// Behavioural model of the flash array program and erase circuitry.
// Assumes the pulse inputs come from the block on the same system clock.
`timescale 1ns/10ps
`default_nettype none
module fts_array_model (
  // Clock.
  input  wire logic clk_i,
  // Activity that the bench orders, and pulses from the block.
  input  wire logic hold_active_i,
  input  wire logic program_pulse_i,
  input  wire logic erase_pulse_i,
  // Array activity level back to the block.
  output logic      array_active_o
);
  // The array reports activity while a pulse runs or while told to stay busy.
  always_ff @(posedge clk_i) begin
    array_active_o <= hold_active_i | program_pulse_i | erase_pulse_i;
  end
endmodule
`default_nettype wire

//--- verif/fts_flash_timing_tb.sv
// Self-checking bench for the flash timing reload and auto-read registers.
// Assumes the checker is bound in and the array model answers activity.
`timescale 1ns/10ps
`default_nettype none
module fts_flash_timing_tb;
  import fts_pkg::*;
  localparam int ESH = 2;
  logic        clk_i, rst_i, reg_wr_i, reg_rd_i, op_req_i, hold_active, usb_ctrl_lowpower_i;
  logic        cpu_stall_o, flash_busy_flag_o, op_done_o, array_active_i, module_erase_o;
  logic        program_pulse_o, erase_pulse_o, usb_xcvr_lowpower_o;
  logic [3:0]  reg_idx_i;
  logic [1:0]  op_kind_i;
  logic [2:0]  seq_phase_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, info0_word_i, info1_word_i;
  logic [7:0]  dflt [8] = '{RST_START_DELAY, RST_TRANSITION, RST_PROGRAM_PULSE,
    RST_PAGE_ERASE, RST_MODULE_ERASE, RST_END_DELAY, RST_MODULE_END, RST_RECOVERY};
  int          t_idx [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 5};
  int          t_kind [9] = '{1, 1, 1, 2, 3, 1, 3, 1, 3};
  int          t_mul [9] = '{1, 2, 8, 1 << ESH, 1 << ESH, 1, 8, 1, 0};
  int          err_count, tests_run, cyc;
  int          base [4];

  fts_flash_timing #(.ERASE_SHIFT(ESH)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .reg_idx_i(reg_idx_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .op_req_i(op_req_i),
    .op_kind_i(op_kind_i), .cpu_stall_o(cpu_stall_o), .flash_busy_flag_o(flash_busy_flag_o),
    .op_done_o(op_done_o), .array_active_i(array_active_i), .info0_word_i(info0_word_i),
    .info1_word_i(info1_word_i), .seq_phase_o(seq_phase_o), .program_pulse_o(program_pulse_o),
    .erase_pulse_o(erase_pulse_o), .module_erase_o(module_erase_o),
    .usb_ctrl_lowpower_i(usb_ctrl_lowpower_i), .usb_xcvr_lowpower_o(usb_xcvr_lowpower_o));
  fts_array_model u_array (.clk_i(clk_i), .hold_active_i(hold_active),
    .program_pulse_i(program_pulse_o), .erase_pulse_i(erase_pulse_o),
    .array_active_o(array_active_i));

  // System clock of 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One register write, strobe high for one cycle.
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    @(negedge clk_i);
    reg_idx_i = idx;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  // One register read, data taken the cycle after the read edge.
  task automatic rdchk(input logic [3:0] idx, input logic [15:0] exp);
    @(negedge clk_i);
    reg_idx_i = idx;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    check($sformatf("reg %0h", idx), reg_rdata_o, exp);
  endtask

  // Runs one operation and counts cycles to its done pulse; registers stay untouched meanwhile.
  task automatic op(input logic [1:0] kind, input bit probe, output int n);
    @(negedge clk_i);
    op_kind_i = kind;
    op_req_i = 1'b1;
    @(negedge clk_i);
    op_req_i = 1'b0;
    n = 0;
    while (op_done_o !== 1'b1 && n < 20000) begin
      @(negedge clk_i);
      n++;
      if (probe && n == 4) check("stall", cpu_stall_o, 1'b1);
      if (n == 1) check("module erase", module_erase_o, kind == OP_MODULE_ERASE);
      op_req_i = probe && (n == 3);
    end
  endtask

  // Synchronous reset held for four cycles with the given information words.
  task automatic do_reset(input logic [15:0] i0, input logic [15:0] i1);
    @(negedge clk_i);
    info0_word_i = i0;
    info1_word_i = i1;
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #6000000;
    err_count++;
    close_out();
  end

  // Main sequence of tests.
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, op_req_i, hold_active, usb_ctrl_lowpower_i} = 6'b100000;
    {reg_idx_i, op_kind_i, reg_wdata_i, info0_word_i, info1_word_i} = '0;
    // The first pass only lets the array activity synchroniser settle to a known level.
    repeat (2) do_reset(16'h0000, 16'h0005);
    for (int i = 0; i < 8; i++) rdchk(4'(i), {8'h00, dflt[i]});
    rdchk(IDX_PRESCALER, {11'h000, RST_PRESCALER});
    check("usb forced", usb_xcvr_lowpower_o, 1'b1);
    wr(IDX_PROT_WORD, 16'hFFFF);
    wr(IDX_CODE_START, 16'hFFFF);
    for (int i = 0; i < 2; i++) begin
      rdchk(i ? IDX_FUNC_WORD_DM : IDX_FUNC_WORD, 16'h0000);
      rdchk(i ? IDX_PROT_WORD_DM : IDX_PROT_WORD, 16'h0005);
      rdchk(i ? IDX_CODE_START_DM : IDX_CODE_START, 16'h1400);
    end
    rdchk(4'hF, 16'h0000);
    $display("test reset values done");
    do_reset(16'h0001, 16'h000A);
    rdchk(IDX_CODE_START, 16'h0A00);
    check("usb follows low", usb_xcvr_lowpower_o, 1'b0);
    usb_ctrl_lowpower_i = 1'b1;
    @(negedge clk_i);
    @(negedge clk_i);
    check("usb follows high", usb_xcvr_lowpower_o, 1'b1);
    usb_ctrl_lowpower_i = 1'b0;
    $display("test auto-read done");
    for (int i = 0; i < 9; i++) wr(4'(i), 16'h0001);
    for (int k = 1; k < 4; k++) op(2'(k), k == 1, base[k]);
    for (int i = 0; i < 9; i++) begin
      wr(4'(t_idx[i]), 16'h0002);
      op(2'(t_kind[i]), 1'b0, cyc);
      check($sformatf("delta %0d", i), cyc - base[t_kind[i]], 2 * t_mul[i]);
      wr(4'(t_idx[i]), 16'h0001);
    end
    wr(IDX_PRESCALER, 16'h0002);
    op(OP_PROGRAM, 1'b0, cyc);
    check("prescaler delta", cyc - base[1], 26);
    $display("test timing done");
    wr(IDX_START_DELAY, 16'h0055);
    hold_active = 1'b1;
    repeat (6) @(negedge clk_i);
    check("busy from array", flash_busy_flag_o, 1'b1);
    do_reset(16'h0001, 16'h000A);
    hold_active = 1'b0;
    repeat (8) @(negedge clk_i);
    rdchk(IDX_START_DELAY, 16'h0055);
    rdchk(IDX_PRESCALER, 16'h0002);
    $display("test busy reset done");
    close_out();
  end
endmodule
`default_nettype wire
